/* File: logic/twmc_pkg.sv */
// Constants and types of the waveform-mode timer channel.
// Assumes an AHB-Lite slave window decoded on the low address byte.
package twmc_pkg;
    // Register byte offsets inside the channel window
    localparam logic [7:0] TWMC_CTRL_OFS = 8'h60;
    localparam logic [7:0] TWMC_MODE_OFS = 8'h64;
    localparam logic [7:0] TWMC_STAT_OFS = 8'h70;
    localparam logic [7:0] TWMC_CNT_OFS = 8'h80;
    localparam logic [7:0] TWMC_RA_OFS = 8'h84;
    localparam logic [7:0] TWMC_RB_OFS = 8'h88;
    localparam logic [7:0] TWMC_RC_OFS = 8'h8c;
    // Control register command bits
    localparam int TWMC_CTL_CLK_ON = 1;
    localparam int TWMC_CTL_CLK_OFF = 2;
    localparam int TWMC_CTL_SOFT = 3;
    // Status register bit positions
    localparam int TWMC_ST_OVF = 0;
    localparam int TWMC_ST_CMPA = 2;
    localparam int TWMC_ST_CMPB = 3;
    localparam int TWMC_ST_CMPC = 4;
    localparam int TWMC_ST_EVT = 7;
    localparam int TWMC_ST_CLKON = 8;
    localparam int TWMC_ST_LVLA = 9;
    localparam int TWMC_ST_LVLB = 10;
    localparam int TWMC_ST_CHGB = 16;
    localparam int TWMC_ST_CHGA = 17;
    localparam int TWMC_ST_CHGX = 18;
    // Prescaler taps giving core clock /2, /8, /32, /128, /1024
    localparam int TWMC_PRE_W = 10;
    localparam int TWMC_TAP2 = 0;
    localparam int TWMC_TAP8 = 2;
    localparam int TWMC_TAP32 = 4;
    localparam int TWMC_TAP128 = 6;
    localparam int TWMC_TAP1024 = 9;
    // Values after reset, and the counter maximum
    localparam logic [31:0] TWMC_MODE_RST = 32'h0000_0000;
    localparam logic [15:0] TWMC_CNT_RST = 16'h0000;
    localparam logic [15:0] TWMC_CMP_RST = 16'hffff;
    localparam logic [15:0] TWMC_CNT_MAX = 16'hffff;
    typedef enum logic [1:0] {
        TWMC_ACT_NONE, TWMC_ACT_SET, TWMC_ACT_CLR, TWMC_ACT_TGL
    } twmc_act_t;
    typedef enum logic [1:0] {
        TWMC_EDG_NONE, TWMC_EDG_RISE, TWMC_EDG_FALL, TWMC_EDG_BOTH
    } twmc_edge_t;
    // Mode register layout, most significant field first
    typedef struct packed {
        twmc_act_t pin_b_on_soft_trigger;
        twmc_act_t pin_b_on_event;
        twmc_act_t pin_b_on_compare_c;
        twmc_act_t pin_b_on_compare_b;
        twmc_act_t pin_a_on_soft_trigger;
        twmc_act_t pin_a_on_event;
        twmc_act_t pin_a_on_compare_c;
        twmc_act_t pin_a_on_compare_a;
        logic waveform_mode;
        logic compare_c_restart_enable;
        logic spare;
        logic event_restart_enable;
        logic [1:0] event_source_select;
        twmc_edge_t event_edge_select;
        logic compare_c_gates_off_clock;
        logic compare_c_halts_counter;
        logic [1:0] burst_select;
        logic count_edge_invert;
        logic [2:0] counter_clock_select;
    } twmc_mode_t;
    // Bus request held from address phase into data phase
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
    } twmc_req_t;
endpackage

/* File: logic/twmc_top.sv */
// Waveform-mode timer channel: counter clocking, compare, events, pins.
// Assumes AHB-Lite single word transfers and pin inputs synchronous to
// the core clock.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
//
// Behaviour
// (RULE1) Select field picks divided or external clock
// (RULE2) Invert bit chooses falling count edge
// (RULE3) Burst field ANDs external line with clock
// (RULE4) Compare C may halt; trigger restarts at zero
// (RULE5) Halting compare C ignores its own trigger
// (RULE6) Compare C may gate clock; command re-enables
// (RULE7) Edge field picks none, rise, fall, both
// (RULE8) Detected event sets event trigger flag
// (RULE9) Event restarts counter when restart bit set
// (RULE10) Source field picks pin B or external line
// (RULE11) Pin B source: single waveform, B inactive
// (RULE12) External source: both pins are outputs
// (RULE13) Triggers start counter only with clock on
// (RULE14) Compare C restarts counter when bit set
// (RULE15) Action codes none, set, clear, toggle
// (RULE16) Pin A has four separate action fields
// (RULE17) Pin A priority: soft, event, C, A
// (RULE18) Pin B fields act only as output
// (RULE19) Pin B priority: soft, event, C, B
// (RULE20) Status read clears the sticky flags
// (RULE21) Overflow flag set on wrap past maximum
// (RULE22) Status mirrors pin levels and clock on
// (RULE23) Change bits read zero after a change
// (RULE24) Event during status read keeps flag set
module twmc_top
    import twmc_pkg::*;
(
    input wire logic I_CLK_SYS, // Core clock, 125 MHz
    input wire logic I_ARST_N, // Asynchronous reset, active low
    input wire logic I_HSEL, // Slave select
    input wire logic [31:0] I_HADDR, // Byte address
    input wire logic [1:0] I_HTRANS, // Transfer type
    input wire logic I_HWRITE, // Write when high
    input wire logic [2:0] I_HSIZE, // Word transfers only
    input wire logic [31:0] I_HWDATA, // Write data
    input wire logic I_HREADY, // Bus ready
    output logic [31:0] O_HRDATA, // Read data
    output logic O_HREADYOUT, // Slave ready
    output logic O_HRESP, // Always OKAY
    input wire logic [2:0] I_EXT_CLK_LINE, // External clock lines 0..2
    input wire logic I_WAVE_PIN_A, // Pin A level
    output logic O_WAVE_PIN_A, // Pin A drive value
    output logic O_WAVE_PIN_A_OE_N, // Pin A enable, low drives
    input wire logic I_WAVE_PIN_B, // Pin B level
    output logic O_WAVE_PIN_B, // Pin B drive value
    output logic O_WAVE_PIN_B_OE_N // Pin B enable, low drives
);
    twmc_mode_t mode_q;
    twmc_req_t req_q;
    logic req_vld_q;
    logic [15:0] ra_q, rb_q, rc_q, cnt_q;
    logic [15:0] cnt_d;
    logic run_q, run_d, on_q, on_d, pend_q, pend_d;
    logic upd_q, upd_d, ovf_d;
    logic [TWMC_PRE_W-1:0] pre_q;
    logic gclk_q, evl_q, pa_q, pb_q;
    logic [2:0] xl_q;
    logic [7:0] flg_q;
    logic [2:0] chg_q;
    logic pin_a_q, pin_b_q, oe_b_n_q;
    logic [31:0] rdata_q;

    // Address phase and data phase qualifiers
    wire take = I_HSEL && I_HTRANS[1] && I_HREADY;
    wire [7:0] aaddr = I_HADDR[7:0];
    wire wr_en = req_vld_q && req_q.wr;
    wire wr_ctrl = wr_en && (req_q.addr == TWMC_CTRL_OFS);
    wire wr_mode = wr_en && (req_q.addr == TWMC_MODE_OFS);
    wire wr_ra = wr_en && (req_q.addr == TWMC_RA_OFS);
    wire wr_rb = wr_en && (req_q.addr == TWMC_RB_OFS);
    wire wr_rc = wr_en && (req_q.addr == TWMC_RC_OFS);
    wire rd_stat = take && !I_HWRITE && (aaddr == TWMC_STAT_OFS);
    wire sw_trg = wr_ctrl && I_HWDATA[TWMC_CTL_SOFT];
    wire cmd_off = wr_ctrl && I_HWDATA[TWMC_CTL_CLK_OFF];
    wire cmd_on = wr_ctrl && I_HWDATA[TWMC_CTL_CLK_ON] && !cmd_off;

    // Counter clock source and burst gate
    wire [2:0] csel = mode_q.counter_clock_select;
    wire src_clk = (csel == 3'h0) ? pre_q[TWMC_TAP2] :
                   (csel == 3'h1) ? pre_q[TWMC_TAP8] :
                   (csel == 3'h2) ? pre_q[TWMC_TAP32] :
                   (csel == 3'h3) ? pre_q[TWMC_TAP128] :
                   (csel == 3'h4) ? pre_q[TWMC_TAP1024] :
                   (csel == 3'h5) ? I_EXT_CLK_LINE[0] :
                   (csel == 3'h6) ? I_EXT_CLK_LINE[1] :
                   I_EXT_CLK_LINE[2]; // [RULE1]
    wire [1:0] bsel = mode_q.burst_select;
    wire bgate = (bsel == 2'h0) ? 1'b1 :
                 I_EXT_CLK_LINE[bsel - 2'h1]; // [RULE3]
    wire gclk = src_clk && bgate; // [RULE3]
    // Edges are seen one core cycle late; fine since the fastest tap
    // toggles at half the core rate.
    wire tick = mode_q.count_edge_invert ? (gclk_q && !gclk) :
                (gclk && !gclk_q); // [RULE2]

    // External event source and edge detector
    wire [1:0] esel = mode_q.event_source_select;
    wire single = (esel == 2'h0); // [RULE11]
    wire evl = single ? I_WAVE_PIN_B :
               I_EXT_CLK_LINE[esel - 2'h1]; // [RULE10]
    wire ev_r = evl && !evl_q;
    wire ev_f = !evl && evl_q;
    wire ev = (mode_q.event_edge_select == TWMC_EDG_RISE) ? ev_r :
              (mode_q.event_edge_select == TWMC_EDG_FALL) ? ev_f :
              (mode_q.event_edge_select == TWMC_EDG_BOTH) ?
              (ev_r || ev_f) : 1'b0; // [RULE7]

    // Compare events, one cycle after the counter takes a new value
    wire cmp_a = upd_q && (cnt_q == ra_q);
    wire cmp_b = upd_q && (cnt_q == rb_q) && !single; // [RULE11]
    wire cmp_c = upd_q && (cnt_q == rc_q);
    wire c_halt = mode_q.compare_c_halts_counter ||
                  mode_q.compare_c_gates_off_clock;
    wire c_trg = cmp_c && mode_q.compare_c_restart_enable &&
                 !c_halt; // [RULE14] [RULE5]
    wire e_trg = ev && mode_q.event_restart_enable; // [RULE9]
    wire trg = sw_trg || e_trg || c_trg;

    // Counter, run and clock-enable next state
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        on_d = on_q;
        pend_d = pend_q;
        upd_d = 1'b0;
        ovf_d = 1'b0;
        if (trg && on_q) begin
            pend_d = 1'b1; // [RULE13]
        end
        if (tick && on_q) begin
            if (pend_q) begin
                cnt_d = TWMC_CNT_RST; // [RULE4]
                run_d = 1'b1;
                pend_d = 1'b0;
                upd_d = 1'b1;
            end else if (run_q) begin
                cnt_d = cnt_q + 16'h0001;
                upd_d = 1'b1;
                ovf_d = (cnt_q == TWMC_CNT_MAX); // [RULE21]
            end
        end
        // A stop on compare C wins over any restart in the same cycle
        if (cmp_c && c_halt) begin
            run_d = 1'b0; // [RULE4] [RULE5]
            pend_d = 1'b0;
        end
        if (cmp_c && mode_q.compare_c_gates_off_clock) begin
            on_d = 1'b0; // [RULE6]
        end
        if (cmd_off) begin
            on_d = 1'b0;
        end else if (cmd_on) begin
            on_d = 1'b1; // [RULE6]
        end
        if (!on_d) begin
            pend_d = 1'b0;
        end
    end

    // Pin action: one event acts, chosen by fixed priority
    function automatic logic act(input logic lvl, input twmc_act_t c);
        case (c)
            TWMC_ACT_SET: act = 1'b1;
            TWMC_ACT_CLR: act = 1'b0;
            TWMC_ACT_TGL: act = !lvl;
            default: act = lvl;
        endcase // [RULE15]
    endfunction
    wire twmc_act_t a_code = sw_trg ? mode_q.pin_a_on_soft_trigger :
                             ev ? mode_q.pin_a_on_event :
                             cmp_c ? mode_q.pin_a_on_compare_c :
                             cmp_a ? mode_q.pin_a_on_compare_a :
                             TWMC_ACT_NONE; // [RULE16] [RULE17]
    wire twmc_act_t b_code = sw_trg ? mode_q.pin_b_on_soft_trigger :
                             ev ? mode_q.pin_b_on_event :
                             cmp_c ? mode_q.pin_b_on_compare_c :
                             cmp_b ? mode_q.pin_b_on_compare_b :
                             TWMC_ACT_NONE; // [RULE19]
    wire pin_a_d = act(pin_a_q, a_code);
    wire pin_b_d = single ? pin_b_q : act(pin_b_q, b_code); // [RULE18]

    // Sticky flags; set terms win over the clear from a status read
    wire [7:0] flg_set = {ev, 2'b00, cmp_c, cmp_b, cmp_a, 1'b0, ovf_d};
    wire [7:0] flg_d = (flg_q & {8{!rd_stat}}) | flg_set; // [RULE24]
    wire [2:0] chg_set = {(|(I_EXT_CLK_LINE ^ xl_q)),
                          I_WAVE_PIN_A ^ pa_q, I_WAVE_PIN_B ^ pb_q};
    wire [2:0] chg_d = (chg_q & {3{!rd_stat}}) | chg_set; // [RULE20]

    // Status word as software sees it
    wire [31:0] stat_w = {13'h0000, ~chg_q, 5'h00,
                          I_WAVE_PIN_B, I_WAVE_PIN_A, on_q,
                          flg_q}; // [RULE22] [RULE23]
    wire [31:0] rd_mux = (aaddr == TWMC_STAT_OFS) ? stat_w :
                         (aaddr == TWMC_MODE_OFS) ? mode_q :
                         (aaddr == TWMC_CNT_OFS) ? {16'h0000, cnt_q} :
                         (aaddr == TWMC_RA_OFS) ? {16'h0000, ra_q} :
                         (aaddr == TWMC_RB_OFS) ? {16'h0000, rb_q} :
                         (aaddr == TWMC_RC_OFS) ? {16'h0000, rc_q} :
                         32'h0000_0000;

    // Bus slave: read data latched at the address phase edge
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            req_vld_q <= 1'b0;
            req_q <= '0;
            rdata_q <= 32'h0000_0000;
        end else begin
            req_vld_q <= take;
            req_q <= '{wr: I_HWRITE, addr: aaddr};
            if (take && !I_HWRITE) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Software-written registers
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            mode_q <= TWMC_MODE_RST;
            ra_q <= TWMC_CMP_RST;
            rb_q <= TWMC_CMP_RST;
            rc_q <= TWMC_CMP_RST;
        end else begin
            if (wr_mode) begin
                mode_q <= I_HWDATA;
            end
            if (wr_ra) begin
                ra_q <= I_HWDATA[15:0];
            end
            if (wr_rb) begin
                rb_q <= I_HWDATA[15:0];
            end
            if (wr_rc) begin
                rc_q <= I_HWDATA[15:0];
            end
        end
    end

    // Prescaler and edge history
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pre_q <= '0;
            gclk_q <= 1'b0;
            evl_q <= 1'b0;
            pa_q <= 1'b0;
            pb_q <= 1'b0;
            xl_q <= 3'h0;
        end else begin
            pre_q <= pre_q + 10'h001;
            gclk_q <= gclk;
            evl_q <= evl;
            pa_q <= I_WAVE_PIN_A;
            pb_q <= I_WAVE_PIN_B;
            xl_q <= I_EXT_CLK_LINE;
        end
    end

    // Counter state and flags
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cnt_q <= TWMC_CNT_RST;
            run_q <= 1'b0;
            on_q <= 1'b0;
            pend_q <= 1'b0;
            upd_q <= 1'b0;
            flg_q <= 8'h00;
            chg_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            on_q <= on_d;
            pend_q <= pend_d;
            upd_q <= upd_d;
            flg_q <= flg_d; // [RULE8] [RULE21] [RULE20]
            chg_q <= chg_d;
        end
    end

    // Waveform pins; pin B turns into an input in single waveform
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
            oe_b_n_q <= 1'b1;
        end else begin
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
            oe_b_n_q <= single; // [RULE11] [RULE12]
        end
    end

    assign O_HRDATA = rdata_q;
    assign O_HREADYOUT = I_ARST_N | 1'b1;
    assign O_HRESP = 1'b0;
    assign O_WAVE_PIN_A = pin_a_q;
    assign O_WAVE_PIN_A_OE_N = 1'b0;
    assign O_WAVE_PIN_B = pin_b_q;
    assign O_WAVE_PIN_B_OE_N = oe_b_n_q;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench of the waveform timer channel over AHB-Lite.
// Assumes the package, twmc_top, its checker and the pin model.
`timescale 1ns/10ps
module testbench
    import twmc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] r;
    logic [2:0] ext_req = 3'h0;
    logic b_val = 1'b0;
    logic [1:0] s;
    logic [1:0] e;
    logic [1:0] acts [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    logic exp_pin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    int want;
    int bad_count = 0;
    int tests_run = 0;
    wire hready, hresp, pa, pa_oe_n, pb, pb_oe_n, wa, wb;
    wire [2:0] ext;
    wire [31:0] hrdata;
    // Core clock, 8 ns period
    always #4 clk = ~clk;
    twmc_top twmc_top_inst (
        .I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_EXT_CLK_LINE(ext),
        .I_WAVE_PIN_A(wa), .O_WAVE_PIN_A(pa), .O_WAVE_PIN_A_OE_N(pa_oe_n),
        .I_WAVE_PIN_B(wb), .O_WAVE_PIN_B(pb), .O_WAVE_PIN_B_OE_N(pb_oe_n)
    );
    twmc_pins_model twmc_pins_model_inst (
        .i_clk(clk), .i_ext_req(ext_req), .i_b_val(b_val), .i_pin_a(pa),
        .i_pin_a_oe_n(pa_oe_n), .i_pin_b(pb), .i_pin_b_oe_n(pb_oe_n),
        .o_ext_line(ext), .o_wire_a(wa), .o_wire_b(wb)
    );
    task automatic final_report();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // Bounded wait for the slave's ready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            bad_count++;
            final_report();
        end
    endtask
    // One single word transfer; read data lands in r
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    // A hang is cut short well beyond the longest run
    initial begin
        #400000;
        bad_count++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, TWMC_MODE_OFS, 32'h0);
        chk(r, TWMC_MODE_RST);
        bus(1'b1, TWMC_MODE_OFS, 32'h5a5a_c5a5);
        bus(1'b0, TWMC_MODE_OFS, 32'h0);
        chk(r, 32'h5a5a_c5a5);
        bus(1'b0, 8'h90, 32'h0);
        bus(1'b0, TWMC_CTRL_OFS, 32'h0);
        // Halt on C with restart also set: trigger without clock is lost
        bus(1'b1, TWMC_RC_OFS, 32'h5);
        bus(1'b1, TWMC_MODE_OFS, 32'h0000_4440);
        bus(1'b1, TWMC_CTRL_OFS, 32'h8);
        repeat (20) @(posedge clk);
        bus(1'b0, TWMC_CNT_OFS, 32'h0);
        chk(r, 32'h0);
        bus(1'b1, TWMC_CTRL_OFS, 32'h2);
        bus(1'b0, TWMC_STAT_OFS, 32'h0);
        chk(32'(r[8]), 32'h1);
        bus(1'b1, TWMC_CTRL_OFS, 32'h8);
        repeat (40) @(posedge clk);
        bus(1'b0, TWMC_CNT_OFS, 32'h0);
        chk(r, 32'h5);
        bus(1'b0, TWMC_CNT_OFS, 32'h0);
        chk(r, 32'h5);
        bus(1'b0, TWMC_STAT_OFS, 32'h0);
        chk(32'(r[4]), 32'h1);
        bus(1'b0, TWMC_STAT_OFS, 32'h0);
        chk(32'(r[4]), 32'h0);
        // Match on C switches the counter clock off until re-enabled
        bus(1'b1, TWMC_MODE_OFS, 32'h0000_0480);
        bus(1'b1, TWMC_CTRL_OFS, 32'h8);
        repeat (40) @(posedge clk);
        bus(1'b0, TWMC_STAT_OFS, 32'h0);
        chk(32'(r[8]), 32'h0);
        bus(1'b1, TWMC_CTRL_OFS, 32'h2);
        bus(1'b0, TWMC_STAT_OFS, 32'h0);
        chk(32'(r[8]), 32'h1);
        // Count rate of every clock source over 2048 core cycles
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, TWMC_MODE_OFS, 32'h400 + 32'(k));
            bus(1'b1, TWMC_CTRL_OFS, 32'h8);
            for (int n = 0; n < 2048; n++) begin
                @(posedge clk);
                if (k > 4) ext_req[k - 5] <= n[2];
            end
            bus(1'b0, TWMC_CNT_OFS, 32'h0);
            want = (k > 4) ? 256 : 2048 >> ((k == 4) ? 10 : 2 * k + 1);
            chk(32'(r + 3 >= want && r <= want + 3), 32'h1);
        end
        ext_req <= 3'h0;
        // Software trigger actions on both pins: set, clear, then toggle twice
        foreach (acts[i]) begin
            bus(1'b1, TWMC_MODE_OFS, {acts[i], 6'h0, acts[i], 22'h400});
            bus(1'b1, TWMC_CTRL_OFS, 32'h8);
            repeat (3) @(posedge clk);
            chk(32'({pa, pb}), 32'({exp_pin[i], exp_pin[i]}));
        end
        // Pin B as event input ignores its own action fields
        bus(1'b1, TWMC_MODE_OFS, {2'h1, 30'h0});
        b_val <= 1'b1;
        bus(1'b1, TWMC_CTRL_OFS, 32'h8);
        repeat (3) @(posedge clk);
        chk(32'({pb, pb_oe_n}), 32'h1);
        bus(1'b0, TWMC_STAT_OFS, 32'h0);
        chk(32'(r[10]), 32'h1);
        // Edge modes on line 0, then both edges on lines 1 and 2
        for (int i = 0; i < 6; i++) begin
            s = (i < 4) ? 2'h1 : 2'(i - 2);
            e = (i < 4) ? 2'(i) : 2'h3;
            bus(1'b1, TWMC_MODE_OFS, {20'h0, s, e, 8'h0});
            bus(1'b0, TWMC_STAT_OFS, 32'h0);
            ext_req[s - 2'h1] <= 1'b1;
            repeat (4) @(posedge clk);
            bus(1'b0, TWMC_STAT_OFS, 32'h0);
            chk(32'({r[7], r[18]}), 32'({e[0], 1'b0}));
            ext_req[s - 2'h1] <= 1'b0;
            repeat (4) @(posedge clk);
            bus(1'b0, TWMC_STAT_OFS, 32'h0);
            chk(32'({r[7], r[18]}), 32'({e[1], 1'b0}));
            bus(1'b0, TWMC_STAT_OFS, 32'h0);
            chk(32'({r[7], r[18]}), 32'h1);
        end
        // Inverted line 0 gated by line 1; dropping the gate is a fall too
        ext_req <= 3'h2;
        bus(1'b1, TWMC_MODE_OFS, 32'h42d);
        bus(1'b1, TWMC_CTRL_OFS, 32'h8);
        for (int j = 0; j < 39; j++) begin
            if (j == 19) begin
                bus(1'b0, TWMC_CNT_OFS, 32'h0);
                chk(r, 32'h8);
                ext_req <= 3'h1;
            end
            repeat (2) @(posedge clk);
            ext_req[0] <= !ext_req[0];
        end
        bus(1'b0, TWMC_CNT_OFS, 32'h0);
        chk(r, 32'h9);
        ext_req <= 3'h0;
        // A rise on line 0 restarts the halted counter only when enabled
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, TWMC_MODE_OFS, 32'h540 | (32'(j) << 12));
            bus(1'b1, TWMC_CTRL_OFS, 32'h8);
            repeat (20) @(posedge clk);
            ext_req <= 3'h1;
            repeat (4) @(posedge clk);
            bus(1'b0, TWMC_CNT_OFS, 32'h0);
            chk(32'(r <= 32'h1), 32'(j));
            ext_req <= 3'h0;
        end
        final_report();
    end
endmodule

/* File: tb/twmc_pins_model.sv */
// Board side of the channel: waveform pin wiring and clock lines.
// Assumes the bench asks for line levels just after a clock edge.
`timescale 1ns/10ps
module twmc_pins_model
(
    input wire logic i_clk, // Core clock
    input wire logic [2:0] i_ext_req, // Wanted line levels
    input wire logic i_b_val, // Level sent into pin B
    input wire logic i_pin_a, // Channel pin A value
    input wire logic i_pin_a_oe_n, // Channel pin A enable
    input wire logic i_pin_b, // Channel pin B value
    input wire logic i_pin_b_oe_n, // Channel pin B enable
    output logic [2:0] o_ext_line = 3'h0, // External clock lines
    output wire logic o_wire_a, // Pin A wire level
    output wire logic o_wire_b // Pin B wire level
);
    // Lines move only at a core edge, as the channel expects them synced
    always @(posedge i_clk) begin
        o_ext_line <= i_ext_req;
    end
    // Pin A has a board pull-up; only the channel ever drives it
    assign o_wire_a = i_pin_a_oe_n ? 1'b1 : i_pin_a;
    // Pin B is driven from outside only while the channel listens
    assign o_wire_b = i_pin_b_oe_n ? i_b_val : i_pin_b;
endmodule

/* File: tb/twmc_props.sv */
// Checker of the timer channel's bus answers and waveform pins.
// Assumes a bind to twmc_top; it watches the top module's ports only.
`timescale 1ns/10ps
module twmc_props
    import twmc_pkg::*;
(
    input wire logic I_CLK_SYS, // Core clock
    input wire logic I_ARST_N, // Reset, active low
    input wire logic I_HSEL, // Slave select
    input wire logic [31:0] I_HADDR, // Byte address
    input wire logic [1:0] I_HTRANS, // Transfer type
    input wire logic I_HWRITE, // Write strobe
    input wire logic [31:0] I_HWDATA, // Write data
    input wire logic I_HREADY, // Bus ready
    input wire logic [31:0] O_HRDATA, // Read data
    input wire logic O_HREADYOUT, // Slave ready
    input wire logic O_HRESP, // Response
    input wire logic I_WAVE_PIN_A, // Pin A wire
    input wire logic I_WAVE_PIN_B, // Pin B wire
    input wire logic O_WAVE_PIN_A, // Pin A drive
    input wire logic O_WAVE_PIN_A_OE_N, // Pin A enable
    input wire logic O_WAVE_PIN_B, // Pin B drive
    input wire logic O_WAVE_PIN_B_OE_N // Pin B enable
);
    logic wr_mode_q; // Mode write in its data phase
    logic rd_stat_q; // Status read in its data phase
    logic rd_zero_q; // Read of a place that answers zero
    logic [31:0] mode_q; // Shadow of the mode register
    // Address phase decode
    wire take = I_HSEL & I_HTRANS[1] & I_HREADY;
    wire [7:0] ofs = I_HADDR[7:0];
    wire [1:0] src = mode_q[11:10];
    wire mapped = ofs inside {TWMC_MODE_OFS, TWMC_STAT_OFS, TWMC_CNT_OFS,
        TWMC_RA_OFS, TWMC_RB_OFS, TWMC_RC_OFS};
    // Shadow lands at the same edge as the design's own mode register
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            wr_mode_q <= 1'b0;
            rd_stat_q <= 1'b0;
            rd_zero_q <= 1'b0;
            mode_q <= TWMC_MODE_RST;
        end else begin
            wr_mode_q <= take & I_HWRITE & (ofs == TWMC_MODE_OFS);
            rd_stat_q <= take & !I_HWRITE & (ofs == TWMC_STAT_OFS);
            rd_zero_q <= take & !I_HWRITE & !mapped;
            if (wr_mode_q) begin
                mode_q <= I_HWDATA;
            end
        end
    end
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_ARST_N);
    property p_okay;
        O_HREADYOUT && !O_HRESP;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus answer not ready or not OKAY");
    property p_pin_a_out;
        !O_WAVE_PIN_A_OE_N;
    endproperty
    a_pin_a_out: assert property (p_pin_a_out)
        else $error("pin A not driven");
    property p_pin_b_in;
        src == 2'h0 && $past(src) == 2'h0 |-> O_WAVE_PIN_B_OE_N;
    endproperty
    a_pin_b_in: assert property (p_pin_b_in)
        else $error("pin B driven while it is the event input");
    property p_pin_b_out;
        src != 2'h0 && $past(src) != 2'h0 |-> !O_WAVE_PIN_B_OE_N;
    endproperty
    a_pin_b_out: assert property (p_pin_b_out)
        else $error("pin B not driven in dual waveform");
    property p_levels;
        rd_stat_q |-> O_HRDATA[10:9] == $past({I_WAVE_PIN_B, I_WAVE_PIN_A});
    endproperty
    a_levels: assert property (p_levels)
        else $error("status pin levels differ from the wires");
    property p_zero_read;
        rd_zero_q |-> O_HRDATA == 32'h0;
    endproperty
    a_zero_read: assert property (p_zero_read)
        else $error("unmapped or control read not zero");
    property p_hold_a;
        (mode_q[23:16] == 8'h0) [*3] |-> $stable(O_WAVE_PIN_A);
    endproperty
    a_hold_a: assert property (p_hold_a)
        else $error("pin A moved with all its actions none");
    property p_hold_b;
        (src == 2'h0) [*3] |-> $stable(O_WAVE_PIN_B);
    endproperty
    a_hold_b: assert property (p_hold_b)
        else $error("pin B moved while it is an input");
endmodule
bind twmc_top twmc_props twmc_props_inst (
    .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_HSEL(I_HSEL),
    .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .I_WAVE_PIN_A(I_WAVE_PIN_A), .I_WAVE_PIN_B(I_WAVE_PIN_B),
    .O_WAVE_PIN_A(O_WAVE_PIN_A), .O_WAVE_PIN_A_OE_N(O_WAVE_PIN_A_OE_N),
    .O_WAVE_PIN_B(O_WAVE_PIN_B), .O_WAVE_PIN_B_OE_N(O_WAVE_PIN_B_OE_N)
);
